/* ols_map.svh */
// register map, field layout, reset values and fixed figures of the overload supervisor
// assumes an includer that uses these names inside SystemVerilog expressions
// Contract
// - Alarm is on while overload content is at or above the alarm level.
// - Alarm level accepts 1 to 100 percent, resets to 90.
// - Assignable relay output follows the alarm while the alarm is present.
// - A trip locks out restarts until content falls strictly below release level.
// - User lockout level accepts 1 to 99 percent, resets to 15.
// - Release select is off or automatic, resets off; off uses the user level.
// - Automatic level frees restart only with headroom for one whole start.
// - Automatic level averages the last four completed starts by integer division.
// - The average is scaled by a 1.25 safety margin.
// - Automatic release level is 100 percent minus the scaled average.
// - Each start command latches the present content as the start reference; during a start, one coinciding with up to speed, abort or trip does not.
// - Only starts reaching up to speed are recorded; aborted or tripped are not.
`ifndef OLS_MAP_SVH
`define OLS_MAP_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OLS_ADR_ALARM    8'h00
`define OLS_ADR_LOCK     8'h04
`define OLS_ADR_CTRL     8'h08
`define OLS_ADR_STATUS   8'h0c
`define OLS_ADR_IRQ_ST   8'h10
`define OLS_ADR_IRQ_CLR  8'h14
`define OLS_ADR_IRQ_EN   8'h18
`define OLS_ADR_CONTENT  8'h1c

// ---------------------------------------------------------------
// fields and limits
// ---------------------------------------------------------------
`define OLS_CTRL_AUTO    0
`define OLS_CTRL_RELAY   1
`define OLS_IRQ_ALARM    0
`define OLS_IRQ_LOCK     1
`define OLS_IRQ_FREE     2
`define OLS_IRQ_REC      3
`define OLS_ALARM_MIN    8'h01
`define OLS_ALARM_MAX    8'h64
`define OLS_ALARM_RST    8'h5a
`define OLS_LOCK_MIN     8'h01
`define OLS_LOCK_MAX     8'h63
`define OLS_LOCK_RST     8'h0f
`define OLS_PCT_FULL     8'h64
`define OLS_AVG_SHIFT    2
`define OLS_MARGIN_NUM   11'h005
`define OLS_MARGIN_SHIFT 2
`define OLS_RESP_OKAY    2'h0
`define OLS_RESP_SLVERR  2'h2

`endif

/* ols_pkg.sv */
// types shared by the overload supervisor and its release calculator
// assumes ols_map.svh is on the include path
`include "ols_map.svh"

package ols_pkg;

  typedef logic [7:0] pct_t;
  typedef pct_t [3:0] hist_t;

  typedef enum logic [0:0] {LK_FREE, LK_LOCKED} lock_st_t;
  typedef enum logic [0:0] {ST_IDLE, ST_STARTING} start_st_t;

  typedef struct packed {
    pct_t        alarm_lvl;
    pct_t        lock_lvl;
    logic        auto_sel;
    logic        relay_en;
    logic        alarm;
    logic        relay;
    lock_st_t    lock;
    start_st_t   start;
    pct_t        start_ref;
    hist_t       hist;
    logic [1:0]  hist_wr;
    logic [2:0]  hist_cnt;
    pct_t        release_lvl;
    logic [3:0]  irq_st;
    logic [3:0]  irq_en;
    logic        irq;
    logic        awready;
    logic        aw_got;
    logic [7:0]  awaddr;
    logic        wready;
    logic        w_got;
    logic [7:0]  wbyte;
    logic        wlane;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sup_state_t;

endpackage : ols_pkg

/* ols_plant.sv */
// partner model: thermal content source and start sequencer
// assumes the bench sets level and event code just after clock edges
`timescale 1ns/1ps
`default_nettype none

module ols_plant (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // bench commands
  input  wire logic [7:0] lvl_i,
  input  wire logic [2:0] ev_i,
  // starter side
  output var  logic [7:0] content_o,
  output var  logic       start_o,
  output var  logic       uts_o,
  output var  logic       abort_o,
  output var  logic       trip_o
);
  // events: 1 start, 2 up to speed, 3 abort, 4 trip, each one cycle
  always_ff @(posedge clk_i) begin
    content_o <= rstn_i ? lvl_i : 8'h00;
    start_o   <= rstn_i && ev_i == 3'h1;
    uts_o     <= rstn_i && ev_i == 3'h2;
    abort_o   <= rstn_i && ev_i == 3'h3;
    trip_o    <= rstn_i && ev_i == 3'h4;
  end
endmodule : ols_plant

`default_nettype wire

/* ols_release_calc.sv */
// automatic lockout release level from the start consumption history
// assumes history entries are whole percent values 0 to 100
`timescale 1ns/1ps
`default_nettype none

module ols_release_calc
  import ols_pkg::*;
(
  // history in
  input  wire hist_t hist_i,
  // level out
  output var  pct_t  level_o
);

  logic [9:0]  sum;
  pct_t        avg;
  logic [10:0] scaled;

  always_comb begin
    sum = '0;
    for (int i = 0; i < 4; i++) begin
      sum = sum + {2'h0, hist_i[i]};
    end
    avg    = 8'(sum >> `OLS_AVG_SHIFT);
    scaled = 11'(({3'h0, avg} * `OLS_MARGIN_NUM) >> `OLS_MARGIN_SHIFT);
    if (scaled >= {3'h0, `OLS_PCT_FULL}) begin
      level_o = '0;
    end else begin
      level_o = `OLS_PCT_FULL - scaled[7:0];
    end
  end

endmodule : ols_release_calc

`default_nettype wire

/* ols_sup_chk.sv */
// port assertions for the overload supervisor
// assumes a bind into ols_supervisor, single clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module ols_sup_chk (
  // clock and reset
  input wire logic        CLK_SYS_I,
  input wire logic        RESETN_I,
  // supervisor
  input wire logic [7:0]  OL_CONTENT_I,
  input wire logic        OL_TRIP_I,
  input wire logic        ALARM_O,
  input wire logic        RELAY_O,
  input wire logic        LOCKOUT_O,
  input wire logic [7:0]  RELEASE_LEVEL_O,
  // bus
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [1:0]  S_AXI_BRESP
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);

  a_alarm_empty: assert property (OL_CONTENT_I == 8'h00 |=> !ALARM_O)
    else $error("alarm high at zero content");
  a_alarm_full: assert property (OL_CONTENT_I >= 8'h64 |=> ALARM_O)
    else $error("alarm low at full content");
  a_relay_alarm: assert property (RELAY_O |-> ALARM_O)
    else $error("relay without alarm");
  a_trip_locks: assert property (OL_TRIP_I |=> LOCKOUT_O)
    else $error("trip did not lock out");
  a_lock_holds: assert property (
    LOCKOUT_O && OL_CONTENT_I >= RELEASE_LEVEL_O |=> LOCKOUT_O)
    else $error("lockout released too early");
  a_lock_frees: assert property (
    LOCKOUT_O && !OL_TRIP_I && OL_CONTENT_I < RELEASE_LEVEL_O |=> !LOCKOUT_O)
    else $error("lockout not released");
  a_level_clamp: assert property (RELEASE_LEVEL_O <= 8'h64)
    else $error("release level above full");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read not answered");
  a_rdata_stand: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_bresp_stand: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
endmodule : ols_sup_chk

`default_nettype wire

/* ols_supervisor.sv */
// overload alarm and restart lockout supervisor with an AXI4-Lite register slave
// assumes overload content in whole percent and single-cycle start, speed, abort, trip pulses
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none

module ols_supervisor
  import ols_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire  logic              CLK_SYS_I,
  input  wire  logic              RESETN_I,
  // thermal model and sequencer
  input  wire  logic [7:0]        OL_CONTENT_I,
  input  wire  logic              OL_TRIP_I,
  input  wire  logic              START_CMD_I,
  input  wire  logic              UP_TO_SPEED_I,
  input  wire  logic              START_ABORT_I,
  // supervisor outputs
  output var   logic              ALARM_O,
  output var   logic              RELAY_O,
  output var   logic              LOCKOUT_O,
  output var   logic [7:0]        RELEASE_LEVEL_O,
  output var   logic              IRQ_O,
  // axi4-lite write address
  input  wire  logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire  logic              S_AXI_AWVALID,
  output var   logic              S_AXI_AWREADY,
  // axi4-lite write data
  input  wire  logic [31:0]       S_AXI_WDATA,
  input  wire  logic [3:0]        S_AXI_WSTRB,
  input  wire  logic              S_AXI_WVALID,
  output var   logic              S_AXI_WREADY,
  // axi4-lite write response
  output var   logic [1:0]        S_AXI_BRESP,
  output var   logic              S_AXI_BVALID,
  input  wire  logic              S_AXI_BREADY,
  // axi4-lite read address
  input  wire  logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire  logic              S_AXI_ARVALID,
  output var   logic              S_AXI_ARREADY,
  // axi4-lite read data
  output var   logic [31:0]       S_AXI_RDATA,
  output var   logic [1:0]        S_AXI_RRESP,
  output var   logic              S_AXI_RVALID,
  input  wire  logic              S_AXI_RREADY
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic in_range(input pct_t v, input pct_t lo, input pct_t hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  function automatic logic [7:0] word_addr(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] al;
    al        = a & ~(ADDR_W'(3));
    word_addr = 8'(al);
  endfunction : word_addr

  // bus response code from a pass or refuse flag
  function automatic logic [1:0] resp_of(input logic ok);
    resp_of = ok ? `OLS_RESP_OKAY : `OLS_RESP_SLVERR;
  endfunction : resp_of

  // content used by one start, never below zero
  function automatic pct_t consumed(input pct_t now, input pct_t ref_lvl);
    consumed = (now > ref_lvl) ? pct_t'(now - ref_lvl) : '0;
  endfunction : consumed

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  // every field named so reset values read at a glance
  localparam sup_state_t RST_STATE = '{
    alarm_lvl:   `OLS_ALARM_RST,
    lock_lvl:    `OLS_LOCK_RST,
    auto_sel:    1'b0,
    relay_en:    1'b0,
    alarm:       1'b0,
    relay:       1'b0,
    lock:        LK_FREE,
    start:       ST_IDLE,
    start_ref:   '0,
    hist:        '0,
    hist_wr:     '0,
    hist_cnt:    '0,
    release_lvl: '0,
    irq_st:      '0,
    irq_en:      '0,
    irq:         1'b0,
    awready:     1'b1,
    aw_got:      1'b0,
    awaddr:      '0,
    wready:      1'b1,
    w_got:       1'b0,
    wbyte:       '0,
    wlane:       1'b0,
    bvalid:      1'b0,
    bresp:       `OLS_RESP_OKAY,
    arready:     1'b1,
    rvalid:      1'b0,
    rdata:       '0,
    rresp:       `OLS_RESP_OKAY
  };

  // registered state and its next value
  sup_state_t  q;
  sup_state_t  d;

  // release levels
  pct_t        auto_lvl;
  pct_t        active_lvl;

  // bus decode
  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        wr_ok;
  logic [31:0] rd;
  logic        rd_ok;

  // interrupt events and start scratch
  logic [3:0]  irq_clr;
  logic [3:0]  irq_evt;
  pct_t        used;

  // ---------------------------------------------------------------
  // release calculator
  // ---------------------------------------------------------------
  ols_release_calc u_calc (
    .hist_i  (q.hist),
    .level_o (auto_lvl)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d       = q;
    irq_clr = '0;
    irq_evt = '0;
    wr_ok   = 1'b1;
    used    = '0;
    rd      = '0;
    rd_ok   = 1'b1;

    // -------------------------------------------------------------
    // write channel capture, address and data in either order
    // -------------------------------------------------------------
    aw_take = S_AXI_AWVALID && q.awready;
    w_take  = S_AXI_WVALID && q.wready;
    ar_take = S_AXI_ARVALID && q.arready;
    if (aw_take) begin
      d.aw_got = 1'b1;
      d.awaddr = word_addr(S_AXI_AWADDR);
    end
    if (w_take) begin
      d.w_got = 1'b1;
      d.wbyte = S_AXI_WDATA[7:0];
      d.wlane = S_AXI_WSTRB[0];
    end

    // -------------------------------------------------------------
    // register write once both halves are held
    // -------------------------------------------------------------
    if (q.aw_got && q.w_got) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      unique case (q.awaddr)
        `OLS_ADR_ALARM: begin
          if (in_range(q.wbyte, `OLS_ALARM_MIN, `OLS_ALARM_MAX)) begin
            if (q.wlane) begin
              d.alarm_lvl = q.wbyte;
            end
          end else begin
            wr_ok = 1'b0;
          end
        end
        `OLS_ADR_LOCK: begin
          if (in_range(q.wbyte, `OLS_LOCK_MIN, `OLS_LOCK_MAX)) begin
            if (q.wlane) begin
              d.lock_lvl = q.wbyte;
            end
          end else begin
            wr_ok = 1'b0;
          end
        end
        `OLS_ADR_CTRL: begin
          if (q.wlane) begin
            d.auto_sel = q.wbyte[`OLS_CTRL_AUTO];
            d.relay_en = q.wbyte[`OLS_CTRL_RELAY];
          end
        end
        `OLS_ADR_IRQ_CLR: begin
          if (q.wlane) begin
            irq_clr = q.wbyte[3:0];
          end
        end
        `OLS_ADR_IRQ_EN: begin
          if (q.wlane) begin
            d.irq_en = q.wbyte[3:0];
          end
        end
        default: begin
          wr_ok = 1'b0;
        end
      endcase
      d.bresp = resp_of(wr_ok);
    end
    if (q.bvalid && S_AXI_BREADY) begin
      d.bvalid = 1'b0;
    end
    d.awready = !d.aw_got && !d.bvalid;
    d.wready  = !d.w_got && !d.bvalid;

    // -------------------------------------------------------------
    // register read
    // -------------------------------------------------------------
    unique case (word_addr(S_AXI_ARADDR))
      `OLS_ADR_ALARM:   rd = {24'h0, q.alarm_lvl};
      `OLS_ADR_LOCK:    rd = {24'h0, q.lock_lvl};
      `OLS_ADR_CTRL:    rd = {30'h0, q.relay_en, q.auto_sel};
      `OLS_ADR_STATUS:  rd = {13'h0, q.hist_cnt, q.release_lvl, 5'h0, q.relay,
                               (q.lock == LK_LOCKED), q.alarm};
      `OLS_ADR_IRQ_ST:  rd = {28'h0, q.irq_st};
      `OLS_ADR_IRQ_CLR: rd = '0;
      `OLS_ADR_IRQ_EN:  rd = {28'h0, q.irq_en};
      `OLS_ADR_CONTENT: rd = {24'h0, OL_CONTENT_I};
      default:          rd_ok = 1'b0;
    endcase
    if (ar_take) begin
      d.rvalid = 1'b1;
      d.rdata  = rd;
      d.rresp  = resp_of(rd_ok);
    end else if (q.rvalid && S_AXI_RREADY) begin
      d.rvalid = 1'b0;
    end
    d.arready = !d.rvalid;

    // -------------------------------------------------------------
    // alarm and relay
    // -------------------------------------------------------------
    d.alarm = (OL_CONTENT_I >= q.alarm_lvl);
    d.relay = d.alarm && q.relay_en;
    if (d.alarm && !q.alarm) begin
      irq_evt[`OLS_IRQ_ALARM] = 1'b1;
    end

    // -------------------------------------------------------------
    // active release level
    // -------------------------------------------------------------
    active_lvl    = q.auto_sel ? auto_lvl : q.lock_lvl;
    d.release_lvl = active_lvl;

    // -------------------------------------------------------------
    // lockout against the level shown on the release output
    // -------------------------------------------------------------
    // a trip in the same cycle keeps it locked
    unique case (q.lock)
      LK_FREE: begin
        if (OL_TRIP_I) begin
          d.lock                 = LK_LOCKED;
          irq_evt[`OLS_IRQ_LOCK] = 1'b1;
        end
      end
      LK_LOCKED: begin
        if (!OL_TRIP_I && (OL_CONTENT_I < q.release_lvl)) begin
          d.lock                 = LK_FREE;
          irq_evt[`OLS_IRQ_FREE] = 1'b1;
        end
      end
    endcase

    // -------------------------------------------------------------
    // start tracking and history
    // -------------------------------------------------------------
    unique case (q.start)
      ST_IDLE: begin
        if (START_CMD_I) begin
          d.start     = ST_STARTING;
          d.start_ref = OL_CONTENT_I;
        end
      end
      ST_STARTING: begin
        if (OL_TRIP_I || START_ABORT_I) begin
          d.start = ST_IDLE;
        end else if (UP_TO_SPEED_I) begin
          d.start = ST_IDLE;
          used = consumed(OL_CONTENT_I, q.start_ref);
          d.hist[q.hist_wr]     = used;
          d.hist_wr             = q.hist_wr + 2'h1;
          irq_evt[`OLS_IRQ_REC] = 1'b1;
          if (q.hist_cnt != 3'h4) begin
            d.hist_cnt = q.hist_cnt + 3'h1;
          end
        end else if (START_CMD_I) begin
          d.start_ref = OL_CONTENT_I;
        end
      end
    endcase

    // -------------------------------------------------------------
    // interrupt status, a new event beats a clear
    // -------------------------------------------------------------
    d.irq_st = (q.irq_st & ~irq_clr) | irq_evt;
    d.irq    = |(d.irq_st & d.irq_en);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // every output is a field of the state register, except LOCKOUT_O, which decodes the lock field
  assign ALARM_O         = q.alarm;
  assign RELAY_O         = q.relay;
  assign LOCKOUT_O       = (q.lock == LK_LOCKED);
  assign RELEASE_LEVEL_O = q.release_lvl;
  assign IRQ_O           = q.irq;
  assign S_AXI_AWREADY   = q.awready;
  assign S_AXI_WREADY    = q.wready;
  assign S_AXI_BVALID    = q.bvalid;
  assign S_AXI_BRESP     = q.bresp;
  assign S_AXI_ARREADY   = q.arready;
  assign S_AXI_RVALID    = q.rvalid;
  assign S_AXI_RDATA     = q.rdata;
  assign S_AXI_RRESP     = q.rresp;

endmodule : ols_supervisor

`default_nettype wire

/* testbench.sv */
// self-checking bench for the overload supervisor
// assumes ols_pkg, the plant model and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import ols_pkg::*;
  logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic        trip, start, uts, abort, alarm, relay, lock, irq;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  lvl, awaddr, araddr, content, rel;
  logic [2:0]  ev;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [31:0] wdata, rdata;
  logic [7:0]  used [4] = '{8'h1e, 8'h1d, 8'h1e, 8'h1b};
  int          miscompares, checks, cyc;

  always #2.5 clk = ~clk;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step

  task automatic setc(input logic [7:0] c);
    lvl <= c;
    step(4);
  endtask : setc

  task automatic pulse(input logic [2:0] e);
    ev <= e;
    step(1);
    ev <= 3'h0;
    step(4);
  endtask : pulse

  task automatic run(input logic [7:0] c0, input logic [7:0] c1);
    setc(c0);
    pulse(3'h1);
    setc(c1);
    pulse(3'h2);
  endtask : run

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (n < 50) begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        bready <= 1'b0;
        chk(bresp, er);
        n = 99;
      end else if (bvalid) bready <= 1'b1;
    end
    if (n == 50) begin
      miscompares++;
      test_done();
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    while (n < 50) begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        rready <= 1'b0;
        chk(rdata, ed);
        chk(rresp, er);
        n = 99;
      end else if (rvalid) rready <= 1'b1;
    end
    if (n == 50) begin
      miscompares++;
      test_done();
    end
  endtask : rd

  function automatic logic [7:0] exp_lvl(input int sum);
    int s;
    s = (sum / 4) * 5 / 4;
    return (s >= 100) ? 8'h00 : 8'(100 - s);
  endfunction : exp_lvl

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {clk, rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {lvl, awaddr, araddr, ev, wdata} = '0;
    wstrb = 4'hf;
    step(16);
    rstn <= 1'b1;
    step(3);
    chk(rel, 8'h0f);
    rd(8'h00, 32'h5a, 2'h0);
    rd(8'h04, 32'h0f, 2'h0);
    rd(8'h08, 32'h00, 2'h0);
    rd(8'h20, 32'h00, 2'h2);
    wr(8'h0c, 32'h01, 2'h2);
    wr(8'h00, 32'h00, 2'h2);
    wr(8'h00, 32'h65, 2'h2);
    rd(8'h00, 32'h5a, 2'h0);
    wr(8'h00, 32'h64, 2'h0);
    rd(8'h00, 32'h64, 2'h0);
    wr(8'h04, 32'h64, 2'h2);
    rd(8'h04, 32'h0f, 2'h0);
    wr(8'h04, 32'h63, 2'h0);
    rd(8'h04, 32'h63, 2'h0);
    wr(8'h04, 32'h0f, 2'h0);
    wr(8'h00, 32'h32, 2'h0);
    wstrb <= 4'h0;
    wr(8'h00, 32'h20, 2'h0);
    wstrb <= 4'hf;
    rd(8'h00, 32'h32, 2'h0);
    $display("test registers done");
    setc(8'h31);
    chk(alarm, 1'b0);
    setc(8'h32);
    chk(alarm, 1'b1);
    wr(8'h08, 32'h02, 2'h0);
    step(2);
    chk(relay, 1'b1);
    setc(8'h31);
    chk(relay, 1'b0);
    wr(8'h08, 32'h00, 2'h0);
    setc(8'h32);
    chk(relay, 1'b0);
    $display("test alarm done");
    setc(8'h28);
    pulse(3'h4);
    setc(8'h0f);
    chk(lock, 1'b1);
    setc(8'h0e);
    chk(lock, 1'b0);
    $display("test lockout done");
    for (int i = 0; i < 4; i++) run(8'h0a, 8'h0a + used[i]);
    setc(8'h05);
    pulse(3'h1);
    setc(8'h5a);
    pulse(3'h3);
    setc(8'h05);
    pulse(3'h1);
    setc(8'h50);
    pulse(3'h4);
    setc(8'h00);
    pulse(3'h2);
    wr(8'h08, 32'h01, 2'h0);
    step(3);
    chk(rel, exp_lvl(116));
    setc(8'h46);
    pulse(3'h4);
    setc(8'h40);
    chk(lock, 1'b1);
    setc(8'h3f);
    chk(lock, 1'b0);
    for (int i = 0; i < 4; i++) run(8'h00, 8'h50);
    chk(rel, exp_lvl(320));
    rd(8'h0c, 32'h00040001, 2'h0);
    rd(8'h1c, 32'h50, 2'h0);
    $display("test auto level done");
    setc(8'h00);
    wr(8'h14, 32'h0f, 2'h0);
    wr(8'h18, 32'h01, 2'h0);
    step(2);
    chk(irq, 1'b0);
    setc(8'h5f);
    chk(irq, 1'b1);
    setc(8'h00);
    wr(8'h14, 32'h01, 2'h0);
    step(2);
    chk(irq, 1'b0);
    wr(8'h18, 32'h00, 2'h0);
    setc(8'h5f);
    chk(irq, 1'b0);
    rd(8'h10, 32'h01, 2'h0);
    $display("test interrupt done");
    test_done();
  end

  ols_plant plant (
    .clk_i(clk), .rstn_i(rstn), .lvl_i(lvl), .ev_i(ev), .content_o(content),
    .start_o(start), .uts_o(uts), .abort_o(abort), .trip_o(trip)
  );

  ols_supervisor dut (
    .CLK_SYS_I(clk), .RESETN_I(rstn), .OL_CONTENT_I(content), .OL_TRIP_I(trip),
    .START_CMD_I(start), .UP_TO_SPEED_I(uts), .START_ABORT_I(abort),
    .ALARM_O(alarm), .RELAY_O(relay), .LOCKOUT_O(lock), .RELEASE_LEVEL_O(rel), .IRQ_O(irq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
  );
endmodule : testbench

bind ols_supervisor ols_sup_chk chk_i (
  .CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .OL_CONTENT_I(OL_CONTENT_I),
  .OL_TRIP_I(OL_TRIP_I), .ALARM_O(ALARM_O), .RELAY_O(RELAY_O), .LOCKOUT_O(LOCKOUT_O),
  .RELEASE_LEVEL_O(RELEASE_LEVEL_O), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_BRESP(S_AXI_BRESP)
);

`default_nettype wire
